// *** hdl/scsu_unit.sv ***
/*
 * execution datapath for storage rotate, register shifts, scaling,
 * the limits compare and the two masked scans.
 * assumes a sequencer issues one start pulse with operands, and a
 * single-word storage port that answers a read with rd_valid later.
 */
//
// Behaviour
// - rotate storage word left, skip if bit23
// - rotate uses address field unindexed
// - designator is sign-extended index plus count
// - only bits 0-5 and 23 are sensed
// - single left shifts rotate end-around
// - single right shifts fill with sign
// - double left shifts rotate 48-bit ring
// - double right shifts fill with sign
// - scaling rotates until bits 46,47 differ
// - zero scaling does exactly 48 shifts
// - residue is count minus shifts, to index
// - opcode 52 selects limits compare
// - compare skips 0, 1 or 2
// - compare keeps registers, -0 not special
// - equality scan steps index one
// - scans compare acc with masked word
// - interval 0 means step of 8
// - threshold scan steps index two
// - scan address recomputed from field plus index
module scsu_unit
    import scsu_pkg::*;
(
    input wire logic clk_in,                    // 40 MHz clock
    input wire logic srst_in,                   // sync reset, active high
    input wire logic start_in,                  // one-cycle operation start
    input wire logic [3:0] op_in,               // operation select
    input wire logic [5:0] opcode_in,           // raw operation code
    input wire logic [ADDR_W-1:0] addr_in,      // address field m
    input wire logic [1:0] index_sel_in,        // index designator b
    input wire logic [WORD_W-1:0] count_in,     // count field k, extended
    input wire logic [2:0] interval_in,         // interval designator i
    input wire logic [WORD_W-1:0] acc_in,       // accumulator
    input wire logic [WORD_W-1:0] quo_in,       // quotient register
    input wire logic [WORD_W-1:0] idx1_in,      // index register 1
    input wire logic [WORD_W-1:0] idx2_in,      // index register 2
    input wire logic [WORD_W-1:0] idx3_in,      // index register 3
    input wire logic [WORD_W-1:0] rd_data_in,   // storage read data
    input wire logic rd_valid_in,               // storage read answer
    output logic mem_rd_out,                    // storage read request
    output logic mem_wr_out,                    // storage write request
    output logic [ADDR_W-1:0] mem_addr_out,     // storage address
    output logic [WORD_W-1:0] mem_wdata_out,    // storage write data
    output logic busy_out,                      // operation in progress
    output logic done_out,                      // one-cycle completion
    output logic [1:0] skip_out,                // instructions to skip
    output logic acc_we_out,                    // load accumulator
    output logic [WORD_W-1:0] acc_out,          // new accumulator
    output logic quo_we_out,                    // load quotient register
    output logic [WORD_W-1:0] quo_out,          // new quotient register
    output logic idx_we_out,                    // load index register
    output logic [1:0] idx_sel_out,             // which index register
    output logic [WORD_W-1:0] idx_out           // new index value
);
    default clocking scsu_cb @(posedge clk_in); endclocking  // checks share one clock
    default disable iff (srst_in);
    // =========================================================
    // state machine
    typedef enum logic [2:0] {
        ST_IDLE, ST_READ, ST_WAIT, ST_NORM, ST_STEP, ST_FINISH
    } scsu_state_t;
    scsu_state_t state_q;
    // latched operation context
    logic [3:0] op_q;                     // operation
    logic [ADDR_W-1:0] addr_q;            // field address
    logic [1:0] bsel_q;                   // index designator
    logic [WORD_W-1:0] kcnt_q;            // count field
    logic [3:0] step_q;                   // decoded interval
    logic [WORD_W-1:0] a_q;               // accumulator copy
    logic [WORD_W-1:0] q_q;               // quotient copy
    logic [WORD_W-1:0] ix_q;              // scan index copy
    logic [DBL_W-1:0] ring_q;             // scaling ring
    logic [RES_W-1:0] nshift_q;           // scaling shift count
    // =========================================================
    // shift designator: index plus count, signs already extended
    logic [WORD_W-1:0] idx_sel_val;       // selected index or zero
    logic [WORD_W-1:0] desig;             // 24-bit designator
    logic [6:0] mag;                      // shift magnitude
    logic go_right;                       // right shift requested

    always_comb begin
        case (index_sel_in)
            2'h1: idx_sel_val = idx1_in;
            2'h2: idx_sel_val = idx2_in;
            2'h3: idx_sel_val = idx3_in;
            default: idx_sel_val = '0;    // b=0 still extends k
        endcase
    end
    assign desig = idx_sel_val + count_in;
    assign go_right = desig[SIGN_BIT];
    assign mag = go_right ? {1'b0, ~desig[CNT_LO_W-1:0]}
                          : {1'b0, desig[CNT_LO_W-1:0]};
    // =========================================================
    // single and double shift results, computed at start
    logic [6:0] rot24;                    // reduced single rotate count
    logic [6:0] rot48;                    // reduced double rotate count
    logic [WORD_W-1:0] single_src;        // register being shifted
    logic [WORD_W-1:0] single_res;        // single result
    logic [DBL_W-1:0] dbl_src;            // combined source
    logic [DBL_W-1:0] dbl_res;            // double result

    always_comb begin
        single_src = (op_in == SCSU_OP_SHIFT_QUO) ? quo_in : acc_in;
        dbl_src = {acc_in, quo_in};
        // magnitude never passes 63, so at most two ring wraps
        rot24 = (mag >= FULL_RING) ? mag - FULL_RING
              : (mag >= HALF_RING) ? mag - HALF_RING : mag;
        rot48 = (mag >= FULL_RING) ? mag - FULL_RING : mag;
        if (go_right) begin
            if (mag >= SINGLE_FILL) begin
                single_res = {WORD_W{single_src[SIGN_BIT]}};
            end else begin
                single_res = WORD_W'($signed(single_src) >>> mag);
            end
            if (mag >= DOUBLE_FILL) begin
                dbl_res = {DBL_W{dbl_src[DBL_W-1]}};
            end else begin
                dbl_res = DBL_W'($signed(dbl_src) >>> mag);
            end
        end else begin
            single_res = WORD_W'({single_src, single_src} >> (7'(WORD_W) - rot24));
            dbl_res = DBL_W'({dbl_src, dbl_src} >> (7'(DBL_W) - rot48));
        end
    end
    // =========================================================
    // masked compare against storage word
    logic [WORD_W-1:0] masked;            // quotient AND word
    logic mc_gt;                          // acc above masked word
    logic mc_eq;                          // acc equal masked word
    assign masked = q_q & rd_data_in;
    scsu_ones_cmp #(.W(WORD_W)) u_scan_cmp (
        .a_in(a_q),
        .b_in(masked),
        .zero_eq_in(1'b1),                // scans merge the two zeros
        .gt_out(mc_gt),
        .eq_out(mc_eq)
    );
    // limits compare: word against acc, quo against word
    logic m_gt_a;                         // operand above upper limit
    logic q_gt_m;                         // lower limit above operand
    scsu_ones_cmp #(.W(WORD_W)) u_upper_cmp (
        .a_in(rd_data_in),
        .b_in(a_q),
        .zero_eq_in(1'b0),                // all-ones is not -0 here
        .gt_out(m_gt_a),
        .eq_out()
    );
    scsu_ones_cmp #(.W(WORD_W)) u_lower_cmp (
        .a_in(q_q),
        .b_in(rd_data_in),
        .zero_eq_in(1'b0),
        .gt_out(q_gt_m),
        .eq_out()
    );
    // next scan index and sign change test
    logic [WORD_W-1:0] ix_next;           // index after step
    logic crossed;                        // positive to negative
    assign ix_next = ix_q - WORD_W'(step_q);
    assign crossed = !ix_q[SIGN_BIT] && ix_next[SIGN_BIT];
    // =========================================================
    // sequencing; strobes are registered one-cycle pulses, busy_out is decoded from state
    logic is_limits;                      // compare selected by opcode
    assign is_limits = (opcode_in == OP_LIMITS_COMPARE);
    always_ff @(posedge clk_in) begin
        if (srst_in) begin  // context registers load at start, so need no reset
            state_q <= ST_IDLE;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            mem_addr_out <= '0;
            mem_wdata_out <= '0;
            done_out <= 1'b0;
            skip_out <= SKIP_NONE;
            acc_we_out <= 1'b0;
            acc_out <= '0;
            quo_we_out <= 1'b0;
            quo_out <= '0;
            idx_we_out <= 1'b0;
            idx_sel_out <= '0;
            idx_out <= '0;
        end else begin
            // pulses last one cycle by default
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            done_out <= 1'b0;
            acc_we_out <= 1'b0;
            quo_we_out <= 1'b0;
            idx_we_out <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_in) begin
                        op_q <= is_limits ? 4'(SCSU_OP_COMPARE) : op_in;
                        addr_q <= addr_in;
                        bsel_q <= index_sel_in;
                        kcnt_q <= count_in;
                        step_q <= (interval_in == 3'h0) ? STEP_ZERO_CODE
                                                        : {1'b0, interval_in};
                        a_q <= acc_in;
                        q_q <= quo_in;
                        ix_q <= (op_in == SCSU_OP_TH_SCAN) ? idx2_in : idx1_in;
                        ring_q <= {acc_in, quo_in};
                        nshift_q <= '0;
                        skip_out <= SKIP_NONE;
                        if (is_limits) begin
                            mem_addr_out <= addr_in;  // effective address given
                            mem_rd_out <= 1'b1;
                            state_q <= ST_WAIT;
                        end else begin
                            case (op_in)
                                SCSU_OP_ROTATE_TEST: begin
                                    mem_addr_out <= addr_in;
                                    mem_rd_out <= 1'b1;
                                    state_q <= ST_WAIT;
                                end
                                SCSU_OP_SHIFT_ACC: begin
                                    acc_we_out <= 1'b1;
                                    acc_out <= single_res;
                                    done_out <= 1'b1;
                                end
                                SCSU_OP_SHIFT_QUO: begin
                                    quo_we_out <= 1'b1;
                                    quo_out <= single_res;
                                    done_out <= 1'b1;
                                end
                                SCSU_OP_SHIFT_DBL: begin
                                    acc_we_out <= 1'b1;
                                    quo_we_out <= 1'b1;
                                    acc_out <= dbl_res[DBL_W-1:WORD_W];
                                    quo_out <= dbl_res[WORD_W-1:0];
                                    done_out <= 1'b1;
                                end
                                SCSU_OP_NORMALIZE: state_q <= ST_NORM;
                                SCSU_OP_EQ_SCAN, SCSU_OP_TH_SCAN: state_q <= ST_STEP;
                                default: done_out <= 1'b1;   // unknown: no effect
                            endcase
                        end
                    end
                end
                ST_NORM: begin
                    // stop when top bits differ or after a full ring
                    if ((ring_q[DBL_W-1] != ring_q[DBL_W-2])
                        || (7'(nshift_q) == FULL_RING)) begin
                        state_q <= ST_FINISH;
                    end else begin
                        ring_q <= {ring_q[DBL_W-2:0], ring_q[DBL_W-1]};
                        nshift_q <= nshift_q + 7'h01;
                    end
                end
                ST_FINISH: begin
                    acc_we_out <= 1'b1;
                    quo_we_out <= 1'b1;
                    acc_out <= ring_q[DBL_W-1:WORD_W];
                    quo_out <= ring_q[WORD_W-1:0];
                    idx_we_out <= (bsel_q != 2'h0);
                    idx_sel_out <= bsel_q;
                    idx_out <= kcnt_q - WORD_W'(nshift_q);
                    done_out <= 1'b1;
                    state_q <= ST_IDLE;
                end
                ST_STEP: begin
                    ix_q <= ix_next;
                    idx_we_out <= 1'b1;
                    idx_sel_out <= (op_q == SCSU_OP_TH_SCAN) ? 2'h2 : 2'h1;
                    idx_out <= ix_next;
                    if (crossed) begin
                        skip_out <= SKIP_NONE;
                        done_out <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        mem_addr_out <= addr_q + ADDR_W'(ix_next);
                        mem_rd_out <= 1'b1;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (rd_valid_in) begin
                        case (op_q)
                            SCSU_OP_ROTATE_TEST: begin
                                mem_wdata_out <= {rd_data_in[WORD_W-2:0],
                                                  rd_data_in[SIGN_BIT]};
                                mem_wr_out <= 1'b1;
                                skip_out <= rd_data_in[SIGN_BIT] ? SKIP_ONE : SKIP_NONE;
                                done_out <= 1'b1;
                                state_q <= ST_IDLE;
                            end
                            SCSU_OP_COMPARE: begin
                                // registers never written here
                                skip_out <= m_gt_a ? SKIP_NONE
                                          : (q_gt_m ? SKIP_ONE : SKIP_TWO);
                                done_out <= 1'b1;
                                state_q <= ST_IDLE;
                            end
                            default: begin
                                if ((op_q == SCSU_OP_EQ_SCAN) ? mc_eq
                                    : (mc_gt || mc_eq)) begin
                                    skip_out <= SKIP_ONE;
                                    done_out <= 1'b1;
                                    state_q <= ST_IDLE;
                                end else begin
                                    state_q <= ST_STEP;
                                end
                            end
                        endcase
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    assign busy_out = (state_q != ST_IDLE);
    // =========================================================
    // checks
    AST_ROT_SKIP: assert property (state_q == ST_WAIT && op_q == SCSU_OP_ROTATE_TEST
        && rd_valid_in |=> mem_wr_out && skip_out == {1'b0, $past(rd_data_in[SIGN_BIT])})
        else $error("rotate skip or write wrong");
    AST_ROT_ADDR: assert property (state_q == ST_WAIT && op_q == SCSU_OP_ROTATE_TEST
        |-> mem_addr_out == addr_q) else $error("rotate address was modified");
    AST_LIMITS_KEEP: assert property (state_q == ST_WAIT && op_q == SCSU_OP_COMPARE
        |=> !acc_we_out && !quo_we_out) else $error("compare wrote a register");
    AST_NORM_BOUND: assert property (state_q == ST_NORM |-> 7'(nshift_q) <= FULL_RING)
        else $error("scaling exceeded 48 shifts");
    AST_DONE_PULSE: assert property (done_out |=> !done_out)
        else $error("done held two cycles");
    AST_SCAN_EXIT: assert property (state_q == ST_STEP && crossed
        |=> done_out && !mem_rd_out && skip_out == SKIP_NONE) else $error("scan exit wrong");
endmodule // scsu_unit

// *** hdl/scsu_pkg.sv ***
/*
 * shared constants for the shift, compare and search execution unit:
 * word widths, opcode values, skip encodings and operation selects.
 * assumes a 24-bit ones'-complement word machine with 15-bit addresses.
 */
package scsu_pkg;
    // =========================================================
    // widths
    localparam int WORD_W = 24;          // data word width
    localparam int DBL_W = 48;           // combined double register width
    localparam int ADDR_W = 15;          // storage address width
    localparam int SIGN_BIT = 23;        // sign position of a word
    localparam int CNT_LO_W = 6;         // sensed low field of designator
    localparam int RES_W = 7;            // residue/shift counter width

    // =========================================================
    // opcode of the limits compare
    localparam logic [5:0] OP_LIMITS_COMPARE = 6'h2A;  // octal 52

    // =========================================================
    // operation select presented with a start pulse
    typedef enum logic [3:0] {
        SCSU_OP_ROTATE_TEST = 4'h0,   // storage_rotate_test
        SCSU_OP_SHIFT_ACC = 4'h1,     // single shift of accumulator
        SCSU_OP_SHIFT_QUO = 4'h2,     // shift_quotient_reg
        SCSU_OP_SHIFT_DBL = 4'h3,     // shift_double_reg
        SCSU_OP_NORMALIZE = 4'h4,     // normalize_double_reg
        SCSU_OP_COMPARE = 4'h5,       // limits_compare (by opcode)
        SCSU_OP_EQ_SCAN = 4'h6,       // masked_equal_scan
        SCSU_OP_TH_SCAN = 4'h7        // masked_threshold_scan
    } scsu_op_t;

    // skip amounts reported with done
    localparam logic [1:0] SKIP_NONE = 2'h0;
    localparam logic [1:0] SKIP_ONE = 2'h1;
    localparam logic [1:0] SKIP_TWO = 2'h2;

    // counts
    localparam logic [6:0] FULL_RING = 7'h30;   // 48 positions
    localparam logic [6:0] HALF_RING = 7'h18;   // 24 positions
    localparam logic [6:0] SINGLE_FILL = 7'h17; // 23: right fill limit
    localparam logic [6:0] DOUBLE_FILL = 7'h2F; // 47: right fill limit
    localparam logic [3:0] STEP_ZERO_CODE = 4'h8; // interval 0 means 8
endpackage : scsu_pkg

// *** hdl/scsu_ones_cmp.sv ***
/*
 * ones'-complement signed comparator of two words.
 * assumes both inputs are full words from the same clock domain.
 */
module scsu_ones_cmp
    import scsu_pkg::*;
#(
    parameter int W = 24            // word width
) (
    input wire logic [W-1:0] a_in,  // left operand
    input wire logic [W-1:0] b_in,  // right operand
    input wire logic zero_eq_in,    // treat +0 and -0 as equal
    output logic gt_out,            // a greater than b
    output logic eq_out             // a equal to b
);
    // =========================================================
    // magnitude ordering: flipping the sign bit maps ones'-complement
    // order onto unsigned order, with -0 just below +0
    logic [W-1:0] a_key;
    logic [W-1:0] b_key;
    logic a_zero;
    logic b_zero;

    assign a_key = {~a_in[W-1], a_in[W-2:0]};
    assign b_key = {~b_in[W-1], b_in[W-2:0]};
    assign a_zero = (a_in == '0) || (a_in == '1);
    assign b_zero = (b_in == '0) || (b_in == '1);

    // both zeros equal only when asked; the compare does not ask
    always_comb begin
        if (zero_eq_in && a_zero && b_zero) begin
            gt_out = 1'b0;
            eq_out = 1'b1;
        end else begin
            gt_out = (a_key > b_key);
            eq_out = (a_in == b_in);
        end
    end
endmodule // scsu_ones_cmp

// *** verification/scsu_mem_model.sv ***
/*
 * behavioural main storage for the execution unit bench.
 * assumes one request at a time; a read answers after 1 or 4 cycles.
 */
module scsu_mem_model
    import scsu_pkg::*;
(
    input wire logic clk_in,                  // bench clock
    input wire logic slow_in,                 // long read latency
    input wire logic mem_rd_in,               // read request
    input wire logic mem_wr_in,               // write request
    input wire logic [ADDR_W-1:0] addr_in,    // word address
    input wire logic [WORD_W-1:0] wdata_in,   // write data
    output logic [WORD_W-1:0] rd_data_out,    // read data
    output logic rd_valid_out                 // read answer pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // storage array and pending read
    logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];  // word store
    logic [WORD_W-1:0] word_q;                 // word being returned
    logic [2:0] wait_q = 3'h0;                 // cycles to answer
    initial begin
        foreach (mem[i]) mem[i] = 24'h000000;
        rd_data_out = 24'h000000;
        rd_valid_out = 1'b0;
    end
    // data toggles outside the answer so a stale sample is caught
    always @(posedge clk_in) begin
        rd_valid_out <= 1'b0;
        rd_data_out <= ~rd_data_out;
        if (mem_wr_in === 1'b1) mem[addr_in] <= wdata_in;
        if (mem_rd_in === 1'b1) begin
            word_q <= mem[addr_in];
            wait_q <= slow_in ? 3'h4 : 3'h1;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
            if (wait_q == 3'h1) begin
                rd_valid_out <= 1'b1;
                rd_data_out <= word_q;
            end
        end
    end
endmodule // scsu_mem_model

// *** verification/tb.sv ***
/*
 * self-checking bench: one task per scenario.
 * assumes the storage model answers reads and applies writes.
 */
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb
    import scsu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // stimulus and observed signals
    logic clk_in = 1'b0, srst_in = 1'b1, start_in = 1'b0, slow = 1'b0;
    logic [3:0] op = 4'h0;
    logic [5:0] opc = 6'h00;
    logic [ADDR_W-1:0] addr = 15'h0000, maddr;
    logic [1:0] bsel = 2'h0, skip, xsel;
    logic [2:0] iv = 3'h1;
    logic [WORD_W-1:0] cnt = 24'h0, acc = 24'h0, quo = 24'h0, x1 = 24'h0, x2 = 24'h0;
    logic [WORD_W-1:0] rdata, wdata, aout, qout, xout;
    logic rvalid, rd, wr, busy, done, awe, qwe, xwe, aw, qw, xw;
    int errors = 0, n_checks = 0, cycles = 0;
    scsu_unit i_dut (.clk_in(clk_in), .srst_in(srst_in), .start_in(start_in), .op_in(op),
        .opcode_in(opc), .addr_in(addr), .index_sel_in(bsel), .count_in(cnt),
        .interval_in(iv), .acc_in(acc), .quo_in(quo), .idx1_in(x1), .idx2_in(x2),
        .idx3_in(24'h000005), .rd_data_in(rdata), .rd_valid_in(rvalid), .mem_rd_out(rd),
        .mem_wr_out(wr), .mem_addr_out(maddr), .mem_wdata_out(wdata), .busy_out(busy),
        .done_out(done), .skip_out(skip), .acc_we_out(awe), .acc_out(aout),
        .quo_we_out(qwe), .quo_out(qout), .idx_we_out(xwe), .idx_sel_out(xsel),
        .idx_out(xout));
    scsu_mem_model i_mem (.clk_in(clk_in), .slow_in(slow), .mem_rd_in(rd), .mem_wr_in(wr),
        .addr_in(maddr), .wdata_in(wdata), .rd_data_out(rdata), .rd_valid_out(rvalid));
    // =========================================================
    // clock, hang guard and verdict
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // ceiling far above the few hundred cycles the run needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // =========================================================
    // one operation: pulse start, wait for done, note write enables
    task automatic go(input logic [3:0] o, input logic [23:0] a, input logic [23:0] q,
                      input logic [23:0] c, input logic [1:0] b);
        int k;
        op <= o;
        acc <= a;
        quo <= q;
        cnt <= c;
        bsel <= b;
        {aw, qw, xw} = 3'h0;
        start_in <= 1'b1;
        @(posedge clk_in);
        {start_in, opc} <= 7'h00;
        for (k = 0; k < 300 && done !== 1'b1; k++) begin
            @(posedge clk_in);
            aw |= awe;
            qw |= qwe;
            xw |= xwe;
        end
        `CHK({done, busy}, 2'h2)
    endtask
    // rotate word in storage; index 1 set to show it is not added
    task automatic t_rot(input logic [14:0] m, input logic s, input logic [23:0] v,
                         input logic [23:0] e, input logic [1:0] es);
        i_mem.mem[m] = v;
        x1 <= 24'h000001;
        addr <= m;
        slow <= s;
        go(SCSU_OP_ROTATE_TEST, 24'h0, 24'h0, 24'h0, 2'h1);
        `CHK(skip, es)
        @(posedge clk_in);
        `CHK(i_mem.mem[m], e)
    endtask
    // register shift; only the target registers are judged
    task automatic sh(input logic [3:0] o, input logic [23:0] a, input logic [23:0] q,
                      input logic [23:0] c, input logic [23:0] ea, input logic [23:0] eq);
        x1 <= 24'h000010;
        go(o, a, q, c, 2'h1 & {1'b0, c == 24'h00000F});
        if (o != SCSU_OP_SHIFT_QUO) `CHK({aw, aout}, {1'b1, ea})
        if (o != SCSU_OP_SHIFT_ACC) `CHK({qw, qout}, {1'b1, eq})
    endtask
    // scaling with residue sent to index register b
    task automatic nm(input logic [23:0] a, input logic [23:0] k, input logic [1:0] b,
                      input logic [23:0] ea, input logic [23:0] er);
        go(SCSU_OP_NORMALIZE, a, 24'h0, k, b);
        `CHK({aout, qout}, {ea, 24'h0})
        `CHK(xw, b != 2'h0)
        if (b != 2'h0) `CHK({xsel, xout}, {b, er})
    endtask
    // limits compare selected by raw opcode alone
    task automatic cp(input logic [23:0] a, input logic [23:0] q, input logic [23:0] m,
                      input logic [1:0] e);
        i_mem.mem[15'h0050] = m;
        addr <= 15'h0050;
        opc <= OP_LIMITS_COMPARE;
        go(SCSU_OP_SHIFT_ACC, a, q, 24'h000003, 2'h0);
        `CHK(skip, e)
        `CHK({aw, qw}, 2'h0)
    endtask
    // masked scan; the index register not in use is left at zero
    task automatic sc(input logic [3:0] o, input logic [23:0] x, input logic [2:0] i,
                      input logic [23:0] a, input logic [23:0] q, input logic [14:0] m,
                      input logic [1:0] e, input logic [23:0] ex);
        x1 <= (o == SCSU_OP_EQ_SCAN) ? x : 24'h0;
        x2 <= (o == SCSU_OP_TH_SCAN) ? x : 24'h0;
        iv <= i;
        addr <= m;
        go(o, a, q, 24'h0, 2'h0);
        `CHK(skip, e)
        if (e != SKIP_NONE) `CHK({xsel, xout}, {(o == SCSU_OP_TH_SCAN) ? 2'h2 : 2'h1, ex})
    endtask
    // =========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        t_rot(15'h0123, 1'b1, 24'h800001, 24'h000003, SKIP_ONE);
        t_rot(15'h0124, 1'b0, 24'h400000, 24'h800000, SKIP_NONE);
        sh(SCSU_OP_SHIFT_ACC, 24'h123456, 24'h0, 24'h000018, 24'h123456, 24'h0);
        sh(SCSU_OP_SHIFT_ACC, 24'h123456, 24'h0, 24'h000043, 24'h91A2B0, 24'h0);
        sh(SCSU_OP_SHIFT_QUO, 24'h0, 24'h123456, 24'h00000F, 24'h0, 24'h1A2B09);
        sh(SCSU_OP_SHIFT_ACC, 24'h800040, 24'h0, 24'hFFFFF9, 24'hFE0001, 24'h0);
        sh(SCSU_OP_SHIFT_QUO, 24'h0, 24'h7FFFFF, 24'hFFFFE8, 24'h0, 24'h000000);
        sh(SCSU_OP_SHIFT_DBL, 24'h800000, 24'h1, 24'h1, 24'h000000, 24'h000003);
        sh(SCSU_OP_SHIFT_DBL, 24'h812345, 24'h0, 24'h30, 24'h812345, 24'h000000);
        sh(SCSU_OP_SHIFT_DBL, 24'h812345, 24'h0, 24'hFFFFD0, 24'hFFFFFF, 24'hFFFFFF);
        nm(24'h000000, 24'h000035, 2'h3, 24'h000000, 24'h000005);
        nm(24'h100000, 24'h00000A, 2'h2, 24'h400000, 24'h000008);
        nm(24'h100000, 24'h00000A, 2'h0, 24'h400000, 24'h000008);
        cp(24'h000064, 24'h00000A, 24'h0000C8, SKIP_NONE);
        cp(24'h000064, 24'h00000A, 24'h000005, SKIP_ONE);
        cp(24'h000064, 24'h00000A, 24'h000032, SKIP_TWO);
        cp(24'h000005, 24'hFFFFF0, 24'hFFFFFA, SKIP_TWO);
        cp(24'h000000, 24'h000000, 24'hFFFFFF, SKIP_ONE);
        i_mem.mem[15'h0201] = 24'h001255;
        sc(SCSU_OP_EQ_SCAN, 24'h3, 3'h1, 24'h55, 24'hFF, 15'h0200, SKIP_ONE, 24'h1);
        sc(SCSU_OP_EQ_SCAN, 24'h10, 3'h0, 24'h55, 24'hFF, 15'h0200, SKIP_NONE, 24'h0);
        sc(SCSU_OP_EQ_SCAN, 24'h2, 3'h2, 24'hFFFFFF, 24'hFFFFFF, 15'h0300, SKIP_ONE, 24'h0);
        i_mem.mem[15'h0404] = 24'h000020;
        i_mem.mem[15'h0403] = 24'hFFFFFE;
        sc(SCSU_OP_TH_SCAN, 24'h5, 3'h1, 24'h10, 24'hFFFFFF, 15'h0400, SKIP_ONE, 24'h3);
        stop_test();
    end
endmodule // tb
